// ==== hdl/control_register_space.sv ====
// control register space: core registers, mapped block decode, uart1 pin mux
// Functional notes
// [R1] core registers answer direct addressing only
// [R2] mapped block reachable by any data access mode
// [R3] mapped block relocatable via two base registers
// [R4] base high bits 23:16, low 15:12 plus enable
// [R5] software writes timing high 51h, then low 40h
// [R6] software waits five no-ops after timing writes
// [R7] clock output enable bit 0, resets enabled
// [R8] receive side clock may clock rx, tx, both
// [R9] transmit side clock may clock rx, tx, both
// [R10] port3 bits 5,6 gpio or uart1 rx/tx
// [R11] port3 bit 7 gpio, irq one, or tx clock
// [R12] shared pin: carrier detect or irq two
// [R13] software leaves bus configuration at reset value
`timescale 1ns/1ps
module control_register_space
  import ctrl_space_pkg::*;
(
  input wire logic clk,                          // system clock, 100 MHz
  input wire logic rst_n,                        // async chip reset, active low
  input wire logic [10:0] creg_addr,             // core register address
  input wire logic creg_direct,                  // access uses direct addressing
  input wire logic creg_wr,                      // write strobe
  input wire logic creg_rd,                      // read strobe
  input wire logic [7:0] creg_wdata,             // write data
  output logic [7:0] creg_rdata,                 // read data, next cycle
  input wire logic data_req,                     // any-mode data access request
  input wire logic [23:0] data_addr,             // data access address
  output logic mmr_sel,                          // access hits mapped block
  output logic [11:0] mmr_offset,                // offset inside mapped block
  output logic clock_output_enable,              // clock output driver enable
  input wire logic brg1_clock,                   // internal uart1 rate clock
  input wire logic receive_side_ext_clock,       // receive side external clock pin
  input wire ctrl_space_pkg::clk_src_t rx_clk_src, // receive clock source
  input wire ctrl_space_pkg::clk_src_t tx_clk_src, // transmit clock source
  output logic uart1_rx_clock,                   // selected receive clock
  output logic uart1_tx_clock,                   // selected transmit clock
  input wire logic p35_uart,                     // bit 5 used as uart receive
  input wire logic p36_uart,                     // bit 6 used as uart transmit
  input wire ctrl_space_pkg::p37_mode_t p37_mode, // bit 7 function
  input wire logic cd_is_irq,                    // shared pin used as irq two
  input wire logic [2:0] gpio_out,               // port3 bits 7:5 gpio data
  input wire logic [2:0] gpio_oe,                // port3 bits 7:5 gpio enables
  output logic [2:0] gpio_in,                    // port3 bits 7:5 pad level
  input wire logic [2:0] p3_pad_in,              // pad inputs bits 7:5
  output logic [2:0] p3_pad_out,                 // pad outputs bits 7:5
  output logic [2:0] p3_pad_oe,                  // pad enables bits 7:5
  input wire logic uart1_transmit,               // uart1 serial data out
  output logic uart1_receive,                    // uart1 serial data in
  output logic external_interrupt_one,           // irq one input, idle high
  input wire logic carrier_detect_or_irq_two,    // shared pin level
  output logic uart1_carrier_detect,             // carrier detect, idle high
  output logic external_interrupt_two            // irq two input, idle high
);
  import ctrl_space_pkg::*;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [7:0] irq_en_hi_q, irq_en_hi_d;  // interrupt_enable_upper
  logic [7:0] dseg_q, dseg_d;        // data_segment
  logic [7:0] eseg_q, eseg_d;        // extra_segment
  logic [7:0] cseg_q, cseg_d;        // code_segment
  logic [7:0] btl_q, btl_d;          // bus_timing_low
  logic [7:0] bth_q, bth_d;          // bus_timing_high
  logic [7:0] mbl_q, mbl_d;          // mmr_base_low
  logic [7:0] mbh_q, mbh_d;          // mmr_base_high
  logic [7:0] cfg_q, cfg_d;          // clock_output_config
  logic [7:0] rdata_q, rdata_d;      // registered read data
  logic wr_ok, rd_ok;                // qualified strobes

  // only a direct-mode access reaches the core registers
  function automatic logic hit(input logic [10:0] a, input logic [10:0] off);
    hit = (a == off);
  endfunction

  // ------------------------------------------------------------
  // register next state
  // ------------------------------------------------------------
  // indirect modes are dropped silently; the core treats them as memory
  always_comb
  begin
    wr_ok = creg_wr & creg_direct;   // R1
    rd_ok = creg_rd & creg_direct;   // R1
    irq_en_hi_d = irq_en_hi_q;
    dseg_d = dseg_q;
    eseg_d = eseg_q;
    cseg_d = cseg_q;
    btl_d = btl_q;
    bth_d = bth_q;
    mbl_d = mbl_q;
    mbh_d = mbh_q;
    cfg_d = cfg_q;
    rdata_d = rdata_q;
    if (wr_ok)
    begin
      if (hit(creg_addr, interrupt_enable_upper_off)) irq_en_hi_d = creg_wdata;
      if (hit(creg_addr, data_segment_off)) dseg_d = creg_wdata;
      if (hit(creg_addr, extra_segment_off)) eseg_d = creg_wdata;
      if (hit(creg_addr, code_segment_off)) cseg_d = creg_wdata;
      // timing order is the writer's duty; hardware takes each write as given
      if (hit(creg_addr, bus_timing_low_off)) btl_d = creg_wdata;
      if (hit(creg_addr, bus_timing_high_off)) bth_d = creg_wdata;
      // base registers relocate the mapped block on the next cycle
      if (hit(creg_addr, mmr_base_low_off)) mbl_d = creg_wdata & base_low_mask;  // R3 R4
      if (hit(creg_addr, mmr_base_high_off)) mbh_d = creg_wdata;                 // R3 R4
      if (hit(creg_addr, clock_output_config_off)) cfg_d = creg_wdata & clock_cfg_mask; // R7
    end
    if (rd_ok)
    begin
      // reserved bus configuration always reads its fixed value
      case (creg_addr)
        interrupt_enable_upper_off: rdata_d = irq_en_hi_q;
        data_segment_off: rdata_d = dseg_q;
        extra_segment_off: rdata_d = eseg_q;
        code_segment_off: rdata_d = cseg_q;
        bus_timing_low_off: rdata_d = btl_q;
        bus_timing_high_off: rdata_d = bth_q;
        bus_configuration_off: rdata_d = bus_configuration_val;
        mmr_base_low_off: rdata_d = mbl_q;
        mmr_base_high_off: rdata_d = mbh_q;
        clock_output_config_off: rdata_d = cfg_q;
        default: rdata_d = zero_rst;  // unmapped reads zero
      endcase
    end
    else if (creg_rd)
    begin
      rdata_d = zero_rst;  // R1
    end
  end

  // register update
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_en_hi_q <= zero_rst;
      dseg_q <= zero_rst;
      eseg_q <= zero_rst;
      cseg_q <= zero_rst;
      btl_q <= bus_timing_low_rst;
      bth_q <= bus_timing_high_rst;
      mbl_q <= mmr_base_low_rst;
      mbh_q <= mmr_base_high_rst;
      cfg_q <= clock_output_config_rst;  // R7
      rdata_q <= zero_rst;
    end
    else
    begin
      irq_en_hi_q <= irq_en_hi_d;
      dseg_q <= dseg_d;
      eseg_q <= eseg_d;
      cseg_q <= cseg_d;
      btl_q <= btl_d;
      bth_q <= bth_d;
      mbl_q <= mbl_d;
      mbh_q <= mbh_d;
      cfg_q <= cfg_d;
      rdata_q <= rdata_d;
    end
  end

  assign creg_rdata = rdata_q;
  assign clock_output_enable = cfg_q[clock_output_enable_bit];  // R7

  // ------------------------------------------------------------
  // mapped block decode
  // ------------------------------------------------------------
  // 4 KB block; any addressing mode that makes a data access may hit it
  always_comb
  begin
    mmr_sel = data_req & mbl_q[mapped_block_enable_bit]
              & (data_addr[23:12] == {mbh_q, mbl_q[base_low_msb:base_low_lsb]});  // R2 R3 R4
    mmr_offset = data_addr[11:0];
  end

  // ------------------------------------------------------------
  // uart1 clock routing and pin functions
  // ------------------------------------------------------------
  // clock muxes are plain gates; a glitch-free switch is the user's concern
  function automatic logic pick_clk(input clk_src_t s, input logic brg, input logic rx_ext,
                                    input logic tx_ext);
    case (s)
      clk_src_receive_ext: pick_clk = rx_ext;
      clk_src_transmit_ext: pick_clk = tx_ext;
      default: pick_clk = brg;
    endcase
  endfunction

  logic tr_clk;  // transmit side clock as taken from bit 7
  always_comb
  begin
    tr_clk = (p37_mode == p37_tx_clock) ? p3_pad_in[2] : 1'b0;                      // R11
    uart1_rx_clock = pick_clk(rx_clk_src, brg1_clock, receive_side_ext_clock, tr_clk); // R8 R9
    uart1_tx_clock = pick_clk(tx_clk_src, brg1_clock, receive_side_ext_clock, tr_clk); // R8 R9
    gpio_in = p3_pad_in;
    // bit 5: receive input only, no drive while in uart use
    p3_pad_out[0] = gpio_out[0];
    p3_pad_oe[0] = p35_uart ? 1'b0 : gpio_oe[0];                // R10
    uart1_receive = p35_uart ? p3_pad_in[0] : 1'b1;             // R10
    // bit 6: transmit output always driven in uart use
    p3_pad_out[1] = p36_uart ? uart1_transmit : gpio_out[1];    // R10
    p3_pad_oe[1] = p36_uart ? 1'b1 : gpio_oe[1];                // R10
    // bit 7: both alternate functions are inputs
    p3_pad_out[2] = gpio_out[2];
    p3_pad_oe[2] = (p37_mode == p37_gpio) ? gpio_oe[2] : 1'b0;  // R11
    external_interrupt_one = (p37_mode == p37_irq_one) ? p3_pad_in[2] : 1'b1;  // R11
    // shared pin: the unused function sees its idle level
    uart1_carrier_detect = cd_is_irq ? 1'b1 : carrier_detect_or_irq_two;  // R12
    external_interrupt_two = cd_is_irq ? carrier_detect_or_irq_two : 1'b1; // R12
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  indirect_write_ignored_a: assert property (  // R1
    creg_wr && !creg_direct |=> $stable(cfg_q) && $stable(mbl_q) && $stable(dseg_q))
    else $error("indirect access changed a core register");
  indirect_read_zero_a: assert property (  // R1
    creg_rd && !creg_direct |=> creg_rdata == 8'h00)
    else $error("indirect read returned data");
  block_hit_a: assert property (  // R2
    data_req && mbl_q[0] && data_addr[23:12] == {mbh_q, mbl_q[7:4]} |-> mmr_sel)
    else $error("mapped block not selected");
  base_high_write_a: assert property (  // R3
    creg_wr && creg_direct && creg_addr == 11'h497 |=> mbh_q == $past(creg_wdata))
    else $error("base high not updated");
  base_low_field_a: assert property (  // R4
    creg_wr && creg_direct && creg_addr == 11'h496 |=> mbl_q == ($past(creg_wdata) & 8'hf1)
      ##1 (creg_rd && creg_direct && creg_addr == 11'h496) [*1] |=> creg_rdata[3:1] == 3'h0)
    else $error("base low field wrong");
  disabled_no_hit_a: assert property (  // R4
    !mbl_q[0] |-> !mmr_sel)
    else $error("block selected while disabled");
  clkout_follow_a: assert property (  // R7
    creg_wr && creg_direct && creg_addr == 11'h499 |=> clock_output_enable == $past(creg_wdata[0]))
    else $error("clock output enable mismatch");
  rx_ext_route_a: assert property (  // R8
    rx_clk_src == clk_src_receive_ext |-> uart1_rx_clock == receive_side_ext_clock)
    else $error("receive clock not routed");
  tx_tr_route_a: assert property (  // R9
    tx_clk_src == clk_src_transmit_ext && p37_mode == p37_tx_clock
      |-> uart1_tx_clock == p3_pad_in[2])
    else $error("transmit clock not routed");
  tx_pin_a: assert property (  // R10
    p36_uart |-> p3_pad_oe[1] && p3_pad_out[1] == uart1_transmit)
    else $error("uart transmit pin not driven");
  p37_input_a: assert property (  // R11
    p37_mode != p37_gpio |-> !p3_pad_oe[2])
    else $error("bit 7 driven in input function");
  shared_pin_a: assert property (  // R12
    cd_is_irq |-> external_interrupt_two == carrier_detect_or_irq_two && uart1_carrier_detect)
    else $error("shared pin routed wrong");

  relocate_c: cover property (creg_wr && creg_direct && creg_addr == 11'h496 ##1 mmr_sel);
  clkout_off_c: cover property (!clock_output_enable);
  tx_clock_c: cover property (p37_mode == p37_tx_clock && tx_clk_src == clk_src_transmit_ext);
endmodule

// ==== hdl/ctrl_space_pkg.sv ====
// constants for the control register space: offsets, reset values, fields
package ctrl_space_pkg;
  // ------------------------------------------------------------
  // core function register offsets (direct address space)
  // ------------------------------------------------------------
  localparam logic [10:0] interrupt_enable_upper_off = 11'h427;
  localparam logic [10:0] data_segment_off = 11'h441;
  localparam logic [10:0] extra_segment_off = 11'h442;
  localparam logic [10:0] code_segment_off = 11'h443;
  localparam logic [10:0] bus_timing_low_off = 11'h468;
  localparam logic [10:0] bus_timing_high_off = 11'h469;
  localparam logic [10:0] bus_configuration_off = 11'h46a;
  localparam logic [10:0] mmr_base_low_off = 11'h496;
  localparam logic [10:0] mmr_base_high_off = 11'h497;
  localparam logic [10:0] clock_output_config_off = 11'h499;
  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] zero_rst = 8'h00;
  localparam logic [7:0] bus_timing_low_rst = 8'h00;  // undefined in hardware, zero chosen
  localparam logic [7:0] bus_timing_high_rst = 8'hff;
  localparam logic [7:0] bus_configuration_val = 8'h07;
  localparam logic [7:0] mmr_base_low_rst = 8'h00;   // only enable bit is defined (0)
  localparam logic [7:0] mmr_base_high_rst = 8'h00;
  localparam logic [7:0] clock_output_config_rst = 8'h01;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int mapped_block_enable_bit = 0;
  localparam int clock_output_enable_bit = 0;
  localparam int base_low_msb = 7;
  localparam int base_low_lsb = 4;
  localparam logic [7:0] base_low_mask = 8'hf1;      // writable bits of base low
  localparam logic [7:0] clock_cfg_mask = 8'h01;     // writable bits of clock config
  // ------------------------------------------------------------
  // pin and clock selections
  // ------------------------------------------------------------
  typedef enum logic [1:0] {clk_src_brg, clk_src_receive_ext, clk_src_transmit_ext} clk_src_t;
  typedef enum logic [1:0] {p37_gpio, p37_irq_one, p37_tx_clock} p37_mode_t;
endpackage

// ==== testbench/testbench.sv ====
// self-checking bench for the control register space
`timescale 1ns/1ps
module testbench;
  import ctrl_space_pkg::*;
  // ------------------------------------------------------------
  // stimulus and observed signals
  // ------------------------------------------------------------
  logic clk = 1'b0; // system clock
  logic rst_n = 1'b0; // chip reset
  logic [10:0] creg_addr = 11'h000;
  logic creg_direct = 1'b0, creg_wr = 1'b0, creg_rd = 1'b0, data_req = 1'b0;
  logic [7:0] creg_wdata = 8'h00, creg_rdata, rv;
  logic [23:0] data_addr = 24'h000000;
  logic mmr_sel, clock_output_enable, brg1_clock = 1'b0, receive_side_ext_clock = 1'b0;
  logic [11:0] mmr_offset;
  clk_src_t rx_clk_src = clk_src_brg, tx_clk_src = clk_src_brg;
  p37_mode_t p37_mode = p37_gpio;
  logic p35_uart = 1'b0, p36_uart = 1'b0, cd_is_irq = 1'b0, uart1_transmit = 1'b1;
  logic [2:0] gpio_out = 3'h0, gpio_oe = 3'h0, p3_pad_in = 3'h7, gpio_in, p3_pad_out, p3_pad_oe;
  logic uart1_rx_clock, uart1_tx_clock, uart1_receive, external_interrupt_one;
  logic carrier_detect_or_irq_two = 1'b1, uart1_carrier_detect, external_interrupt_two;
  int err_count = 0;
  int total_checks = 0;
  int seed = 42856;
  logic [23:0] r; // random word
  logic [7:0] hb, lb; // base register images
  // register table: offset, value before the loop, readable after write mask
  // timing registers hold their start-up values, not their reset values
  logic [10:0] offs [10] = '{interrupt_enable_upper_off, data_segment_off, extra_segment_off,
    code_segment_off, bus_timing_low_off, bus_timing_high_off, bus_configuration_off,
    mmr_base_low_off, mmr_base_high_off, clock_output_config_off};
  logic [7:0] rsts [10] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h51, 8'h07, 8'h00, 8'h00, 8'h01};
  logic [7:0] msks [10] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00, 8'hf1, 8'hff, 8'h01};
  always #5 clk = ~clk;
  control_register_space control_register_space_i (.clk(clk), .rst_n(rst_n),
    .creg_addr(creg_addr), .creg_direct(creg_direct), .creg_wr(creg_wr), .creg_rd(creg_rd),
    .creg_wdata(creg_wdata), .creg_rdata(creg_rdata), .data_req(data_req), .data_addr(data_addr),
    .mmr_sel(mmr_sel), .mmr_offset(mmr_offset), .clock_output_enable(clock_output_enable),
    .brg1_clock(brg1_clock), .receive_side_ext_clock(receive_side_ext_clock),
    .rx_clk_src(rx_clk_src), .tx_clk_src(tx_clk_src), .uart1_rx_clock(uart1_rx_clock),
    .uart1_tx_clock(uart1_tx_clock), .p35_uart(p35_uart), .p36_uart(p36_uart),
    .p37_mode(p37_mode), .cd_is_irq(cd_is_irq), .gpio_out(gpio_out), .gpio_oe(gpio_oe),
    .gpio_in(gpio_in), .p3_pad_in(p3_pad_in), .p3_pad_out(p3_pad_out), .p3_pad_oe(p3_pad_oe),
    .uart1_transmit(uart1_transmit), .uart1_receive(uart1_receive),
    .external_interrupt_one(external_interrupt_one),
    .carrier_detect_or_irq_two(carrier_detect_or_irq_two),
    .uart1_carrier_detect(uart1_carrier_detect), .external_interrupt_two(external_interrupt_two));
  // ------------------------------------------------------------
  // compare, bus and closing tasks
  // ------------------------------------------------------------
  task automatic chk_val(input string what, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    if (err_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // one write strobe, released at the next edge
  task automatic wr(input logic [10:0] a, input logic [7:0] d, input logic dir);
    @(posedge clk);
    creg_addr <= a;
    creg_wdata <= d;
    creg_direct <= dir;
    creg_wr <= 1'b1;
    @(posedge clk);
    creg_wr <= 1'b0;
  endtask
  // read data is settled just after the edge that took the strobe
  task automatic rd(input logic [10:0] a, input logic dir, output logic [7:0] d);
    @(posedge clk);
    creg_addr <= a;
    creg_direct <= dir;
    creg_rd <= 1'b1;
    @(posedge clk);
    creg_rd <= 1'b0;
    #1 d = creg_rdata;
  endtask
  // expected selected clock; unused select code falls back to the rate clock
  function automatic logic clk_exp(input clk_src_t s, input logic b, input logic rx,
                                   input logic tx);
    return (s == clk_src_receive_ext) ? rx : (s == clk_src_transmit_ext) ? tx : b;
  endfunction
  // watchdog: a hang counts as a mismatch
  initial
  begin
    #500us err_count++;
    test_done();
  end
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    r = 24'($random(seed));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    // start-up bus timing writes, high first, then five idle cycles
    wr(bus_timing_high_off, 8'h51, 1'b1);
    wr(bus_timing_low_off, 8'h40, 1'b1);
    repeat (5) @(posedge clk);
    #1 chk_val("clkout enable after reset", 24'h1, clock_output_enable);
    data_req <= 1'b1;
    #1 chk_val("select with block disabled", 24'h0, mmr_sel);
    for (int i = 0; i < 10; i++)
    begin
      rd(offs[i], 1'b1, rv);
      chk_val("reset value", rsts[i], rv);
      r = 24'($random(seed));
      // reserved bus configuration only ever sees its own value
      if (offs[i] == bus_configuration_off) r[7:0] = bus_configuration_val;
      wr(offs[i], r[7:0], 1'b0); // indirect write must not land
      rd(offs[i], 1'b0, rv);
      chk_val("indirect read", 24'h0, rv);
      rd(offs[i], 1'b1, rv);
      chk_val("after indirect write", rsts[i], rv);
      wr(offs[i], r[7:0], 1'b1);
      rd(offs[i], 1'b1, rv);
      chk_val("read back", (r[7:0] & msks[i]) | (rsts[i] & ~msks[i]), rv);
    end
    rd(11'h4ff, 1'b1, rv);
    chk_val("unmapped read", 24'h0, rv);
    wr(clock_output_config_off, 8'h00, 1'b1);
    #1 chk_val("clkout disabled", 24'h0, clock_output_enable);
    wr(clock_output_config_off, 8'hff, 1'b1);
    #1 chk_val("clkout enabled", 24'h1, clock_output_enable);
    // relocate the mapped block to random bases and probe hits and misses
    for (int k = 0; k < 20; k++)
    begin
      r = 24'($random(seed));
      hb = r[7:0];
      lb = {r[11:8], 4'h1};
      wr(mmr_base_high_off, hb, 1'b1);
      wr(mmr_base_low_off, lb ^ {7'h00, k[0]}, 1'b1);
      data_addr <= {hb, lb[7:4], r[23:12]};
      data_req <= 1'b1;
      @(posedge clk);
      #1 chk_val("mapped hit", {23'h0, ~k[0]}, mmr_sel);
      chk_val("mapped offset", {12'h0, r[23:12]}, mmr_offset);
      data_addr <= {hb ^ (8'h01 << k[2:0]), lb[7:4], r[23:12]};
      @(posedge clk);
      #1 chk_val("mapped miss", 24'h0, mmr_sel);
      data_req <= 1'b0;
      data_addr <= {hb, lb[7:4], r[23:12]};
      @(posedge clk);
      #1 chk_val("no request", 24'h0, mmr_sel);
    end
    // random pin functions and levels
    for (int n = 0; n < 300; n++)
    begin
      @(posedge clk);
      r = 24'($random(seed));
      {brg1_clock, receive_side_ext_clock, p35_uart, p36_uart, cd_is_irq} <= r[4:0];
      {uart1_transmit, carrier_detect_or_irq_two} <= r[6:5];
      {gpio_out, gpio_oe, p3_pad_in} <= r[15:7];
      rx_clk_src <= clk_src_t'(r[17:16]);
      tx_clk_src <= clk_src_t'(r[19:18]);
      p37_mode <= p37_mode_t'(r[21:20]);
      #1 chk_val("gpio in", {21'h0, p3_pad_in}, gpio_in);
      if (rx_clk_src != clk_src_transmit_ext || p37_mode == p37_tx_clock)
        chk_val("rx clock", clk_exp(rx_clk_src, brg1_clock, receive_side_ext_clock,
          p3_pad_in[2]), uart1_rx_clock);
      if (tx_clk_src != clk_src_transmit_ext || p37_mode == p37_tx_clock)
        chk_val("tx clock", clk_exp(tx_clk_src, brg1_clock, receive_side_ext_clock,
          p3_pad_in[2]), uart1_tx_clock);
      chk_val("uart receive", p35_uart ? p3_pad_in[0] : 1'b1, uart1_receive);
      chk_val("bit5 enable", p35_uart ? 1'b0 : gpio_oe[0], p3_pad_oe[0]);
      chk_val("bit6 enable", p36_uart ? 1'b1 : gpio_oe[1], p3_pad_oe[1]);
      chk_val("bit6 out", p36_uart ? uart1_transmit : gpio_out[1], p3_pad_out[1]);
      chk_val("irq one", (p37_mode == p37_irq_one) ? p3_pad_in[2] : 1'b1,
        external_interrupt_one);
      chk_val("bit7 enable", (p37_mode == p37_gpio) ? gpio_oe[2] : 1'b0, p3_pad_oe[2]);
      chk_val("carrier detect", cd_is_irq ? 1'b1 : carrier_detect_or_irq_two,
        uart1_carrier_detect);
      chk_val("irq two", cd_is_irq ? carrier_detect_or_irq_two : 1'b1,
        external_interrupt_two);
    end
    test_done();
  end
endmodule
